// File: acc_conv_model.sv
// Behavioural converter answering start requests after a fixed delay.
`timescale 1ns/100ps
module acc_conv_model #(
  parameter int LAT = 6
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Control side
  input  wire logic conv_start,
  input  wire logic conv_abort,
  input  wire logic ge_level,
  // Answer side
  output logic      conv_done,
  output logic      compare_ge
);
  int cnt;

  // Outside the done pulse the comparator level is inverted, so a design
  // that samples it at the wrong moment sees the wrong answer.
  assign compare_ge = conv_done ? ge_level : ~ge_level;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= 0;
      conv_done <= 1'h0;
    end else begin
      if (conv_start) cnt <= LAT;
      else if (conv_abort) cnt <= 0;
      else if (cnt != 0) cnt <= cnt - 1;
      conv_done <= (cnt == 1) && !conv_start && !conv_abort;
    end
  end
endmodule : acc_conv_model

// File: acc_ctrl.sv
// Control and status registers of the successive approximation converter.
`timescale 1ns/100ps
module acc_ctrl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Converter and result side
  input  wire logic        conv_done,
  input  wire logic        compare_ge,
  input  wire logic        result_low_read,
  input  wire logic        hardware_trigger_in,
  output logic             conv_start,
  output logic             conv_abort,
  output logic             result_load,
  output logic      [4:0]  channel_select,
  output logic             conv_low_power,
  output logic             input_isolate,
  // Interrupt request
  output logic             conv_irq
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0] chan_r;
  logic       done_r;
  logic       ien_r;
  logic       cont_r;
  logic       active_r;
  logic       trig_hw_r;
  logic       cmp_en_r;
  logic       cmp_ge_r;
  logic       start_r;
  logic       abort_r;
  logic       load_r;
  logic       irq_r;
  logic       low_pwr_r;
  logic       isolate_r;
  logic [7:0] rdata_r;

  logic       done_nxt;
  logic       ien_nxt;
  logic       active_nxt;
  logic [4:0] chan_nxt;

  logic       wr_a;
  logic       wr_b;
  logic       hw_evt;
  logic       done_evt;
  logic       cmp_true;
  logic       flag_set;
  logic       new_off;
  logic       start_sw;
  logic       start_hw;
  logic       start_cont;
  logic       start_req;

  // ----------------------------------------------------------------
  // Hardware trigger front end
  // ----------------------------------------------------------------
  acc_trig_edge acc_trig_edge_inst (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .trig_in    (hardware_trigger_in),
    .trig_pulse (hw_evt)
  );

  // ----------------------------------------------------------------
  // Decode and start sources
  // ----------------------------------------------------------------
  // A completion is only believed while a conversion is running, so a
  // late done from a conversion aborted without a restart cannot set the flag.
  always_comb begin
    wr_a     = reg_wr && (reg_sel == ACC_SEL_A);
    wr_b     = reg_wr && (reg_sel == ACC_SEL_B);
    done_evt = conv_done && active_r;
    cmp_true = cmp_ge_r ? compare_ge : !compare_ge;
    flag_set = done_evt && (!cmp_en_r || cmp_true);
    chan_nxt = wr_a ? reg_wdata[ACC_A_CH_MSB:ACC_A_CH_LSB] : chan_r;
    new_off  = (chan_nxt == ACC_CH_OFF);
    // Write start in software mode; the write itself is the trigger.
    start_sw = wr_a && !new_off && !trig_hw_r;
    // Hardware start; triggers while busy are dropped, not queued.
    start_hw = !wr_a && trig_hw_r && hw_evt && !active_r && !new_off;
    // Back to back restart only in continuous mode.
    start_cont = !wr_a && done_evt && cont_r && !new_off;
    start_req  = start_sw || start_hw || start_cont;
  end

  // ----------------------------------------------------------------
  // Next values for flags
  // ----------------------------------------------------------------
  // The set wins over a clear arriving in the same cycle, so a finished
  // conversion is never lost behind a register access.
  always_comb begin
    ien_nxt = wr_a ? reg_wdata[ACC_A_IEN] : ien_r;
    if (flag_set) begin
      done_nxt = 1'h1;
    end else if (wr_a || result_low_read) begin
      done_nxt = 1'h0;
    end else begin
      done_nxt = done_r;
    end
    if (start_req) begin
      active_nxt = 1'h1;
    end else if (done_evt || wr_a) begin
      active_nxt = 1'h0;
    end else begin
      active_nxt = active_r;
    end
  end

  // ----------------------------------------------------------------
  // Register A
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chan_r <= ACC_CH_RST;
      ien_r  <= ACC_BIT_RST;
      cont_r <= ACC_BIT_RST;
      done_r <= ACC_BIT_RST;
    end else begin
      chan_r <= chan_nxt;
      ien_r  <= ien_nxt;
      if (wr_a) begin
        cont_r <= reg_wdata[ACC_A_CONT];
      end
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register B
  // ----------------------------------------------------------------
  // The low bits are not stored, so what software writes there is moot.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trig_hw_r <= ACC_BIT_RST;
      cmp_en_r  <= ACC_BIT_RST;
      cmp_ge_r  <= ACC_BIT_RST;
    end else if (wr_b) begin
      trig_hw_r <= reg_wdata[ACC_B_TRIG];
      cmp_en_r  <= reg_wdata[ACC_B_CMP_EN];
      cmp_ge_r  <= reg_wdata[ACC_B_CMP_GE];
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_r  <= ACC_BIT_RST;
      start_r   <= 1'h0;
      abort_r   <= 1'h0;
      low_pwr_r <= 1'h1;
      isolate_r <= 1'h1;
    end else begin
      active_r  <= active_nxt;
      start_r   <= start_req;
      abort_r   <= wr_a && active_r && !done_evt;
      low_pwr_r <= !active_nxt;
      isolate_r <= new_off;
    end
  end

  // ----------------------------------------------------------------
  // Result load and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      load_r <= 1'h0;
      irq_r  <= 1'h0;
    end else begin
      load_r <= flag_set;
      irq_r  <= done_nxt && ien_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= ACC_RDATA_RST;
    end else if (reg_rd) begin
      if (reg_sel == ACC_SEL_A) begin
        rdata_r <= {done_r, ien_r, cont_r, chan_r};
      end else begin
        rdata_r <= {active_r, trig_hw_r, cmp_en_r, cmp_ge_r, ACC_B_LOW_RD};
      end
    end
  end

  assign reg_rdata      = rdata_r;
  assign conv_start     = start_r;
  assign conv_abort     = abort_r;
  assign result_load    = load_r;
  assign channel_select = chan_r;
  assign conv_low_power = low_pwr_r;
  assign input_isolate  = isolate_r;
  assign conv_irq       = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_done_plain;
    conv_done && active_r && !cmp_en_r;
  endsequence

  sequence s_done_cmp_false;
    conv_done && active_r && cmp_en_r && !cmp_true
      && !wr_a && !result_low_read;
  endsequence

  sequence s_single_end;
    conv_done && active_r && !cont_r && !wr_a;
  endsequence

  a_sw_write_start: assert property (
    wr_a && (reg_wdata[ACC_A_CH_MSB:ACC_A_CH_LSB] != ACC_CH_OFF)
      && !trig_hw_r |=> start_r && active_r && !$past(start_r))
    else $error("software write did not start a conversion");

  a_off_stops_all: assert property (
    wr_a && (reg_wdata[ACC_A_CH_MSB:ACC_A_CH_LSB] == ACC_CH_OFF)
      |=> !active_r && !start_r && input_isolate ##1 !start_r)
    else $error("disable code did not stop conversions");

  a_done_plain_set: assert property (
    s_done_plain |=> done_r && result_load)
    else $error("completion without compare did not set done");

  a_cmp_false_hold: assert property (
    s_done_cmp_false |=> $stable(done_r) && !result_load)
    else $error("false compare changed done or loaded result");

  a_done_clears: assert property (
    (wr_a || result_low_read) && !(conv_done && active_r) |=> !done_r)
    else $error("done flag not cleared by write or low read");

  a_irq_follows: assert property (
    $rose(done_r) && ien_r |-> conv_irq)
    else $error("interrupt missing when done set");

  a_single_idle: assert property (
    s_single_end |=> !active_r && conv_low_power ##1 !start_r)
    else $error("single conversion did not return to low power");

  a_cont_restart: assert property (
    conv_done && active_r && cont_r && !wr_a && chan_r != ACC_CH_OFF
      |=> start_r && active_r)
    else $error("continuous mode did not restart");

  a_hw_start: assert property (
    hw_evt && trig_hw_r && !active_r && !wr_a && chan_r != ACC_CH_OFF
      |=> start_r ##1 active_r)
    else $error("hardware trigger did not start a conversion");

  a_sw_no_hw: assert property (
    hw_evt && !trig_hw_r && !wr_a && !active_r |=> !start_r)
    else $error("hardware trigger started in software mode");

  a_active_abort: assert property (
    wr_a && active_r && trig_hw_r && !conv_done |=> !active_r && conv_abort)
    else $error("write did not abort the running conversion");

  // ----------------------------------------------------------------
  // Invariants
  // ----------------------------------------------------------------
  // These tie the outputs to the register state, so a drift between
  // what software reads and what the converter is told shows at once.
  sequence s_done_ge_true;
    conv_done && active_r && cmp_en_r && cmp_ge_r && compare_ge;
  endsequence

  sequence s_done_lt_true;
    conv_done && active_r && cmp_en_r && !cmp_ge_r && !compare_ge;
  endsequence

  a_done_ro_write: assert property (
    wr_a && reg_wdata[ACC_A_DONE] && !flag_set |=> !done_r)
    else $error("written value reached the done flag");

  a_done_holds: assert property (
    !flag_set && !wr_a && !result_low_read |=> $stable(done_r))
    else $error("done flag changed without a cause");

  a_ge_true_set: assert property (
    s_done_ge_true |=> done_r && result_load)
    else $error("greater or equal compare did not set done");

  a_lt_true_set: assert property (
    s_done_lt_true |=> done_r && result_load)
    else $error("less than compare did not set done");

  a_load_with_done: assert property (
    result_load |-> done_r)
    else $error("result loaded without done flag");

  a_irq_level: assert property (
    conv_irq == (done_r && ien_r))
    else $error("interrupt does not match flag and enable");

  a_chan_holds: assert property (
    !wr_a |=> $stable(channel_select))
    else $error("channel changed without a write");

  a_isolate_off: assert property (
    input_isolate == (channel_select == ACC_CH_OFF))
    else $error("isolation does not match channel code");

  a_no_start_off: assert property (
    conv_start |-> channel_select != ACC_CH_OFF)
    else $error("conversion started while disabled");

  a_single_no_start: assert property (
    !cont_r && !trig_hw_r && !wr_a |=> !conv_start)
    else $error("single mode started without a write");

  a_start_active: assert property (
    conv_start |-> active_r)
    else $error("start without active indication");

  a_low_power_idle: assert property (
    conv_low_power == !active_r)
    else $error("low power does not match activity");

  a_abort_cause: assert property (
    conv_abort |-> conv_start || input_isolate || trig_hw_r)
    else $error("abort without restart, disable or trigger wait");

  a_hw_busy_drop: assert property (
    hw_evt && active_r && !conv_done && !wr_a |=> !conv_start)
    else $error("hardware trigger accepted while busy");

  a_trig_one_pulse: assert property (
    hw_evt |=> !hw_evt)
    else $error("trigger pulse longer than one cycle");

endmodule : acc_ctrl

// File: acc_ctrl_tb.sv
// Self-checking bench for the converter control and status block.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module acc_ctrl_tb;
  import acc_pkg::*;
  logic       core_clk = 1'h0;
  logic       nrst = 1'h0;
  logic       reg_sel = 1'h0;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       ge_level = 1'h0;
  logic       result_low_read = 1'h0;
  logic       hardware_trigger_in = 1'h0;
  logic [7:0] reg_rdata;
  logic [4:0] channel_select;
  logic       conv_done, compare_ge, conv_start, conv_abort;
  logic       result_load, conv_low_power, input_isolate, conv_irq;
  int         failures = 0;
  int         cmp_count = 0;
  int         c;

  acc_ctrl acc_ctrl_inst (.core_clk(core_clk), .nrst(nrst),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .compare_ge(compare_ge), .result_low_read(result_low_read),
    .hardware_trigger_in(hardware_trigger_in), .conv_start(conv_start),
    .conv_abort(conv_abort), .result_load(result_load),
    .channel_select(channel_select), .conv_low_power(conv_low_power),
    .input_isolate(input_isolate), .conv_irq(conv_irq));
  acc_conv_model acc_conv_model_inst (.core_clk(core_clk), .nrst(nrst),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .ge_level(ge_level), .conv_done(conv_done), .compare_ge(compare_ge));

  always #10 core_clk = ~core_clk;

  task automatic close_out();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic s, input logic [7:0] d);
    tick();
    reg_sel   = s;
    reg_wdata = d;
    reg_wr    = 1'h1;
    tick();
    reg_wr    = 1'h0;
  endtask : wr

  task automatic rd(input logic s, input logic [7:0] e);
    tick();
    reg_sel = s;
    reg_rd  = 1'h1;
    tick();
    reg_rd  = 1'h0;
    `CHK(reg_rdata, e)
  endtask : rd

  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && conv_done !== 1'h1; i++) tick();
    if (i == 40) begin
      failures++;
      close_out();
    end else begin
      tick();
    end
  endtask : wait_done

  task automatic starts(input int n);
    c = 0;
    repeat (n) begin
      tick();
      c += (conv_start === 1'h1);
    end
  endtask : starts

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(channel_select, ACC_CH_OFF)
    `CHK({conv_low_power, input_isolate, conv_irq}, 3'h6)
    rd(ACC_SEL_A, 8'h1f);
    rd(ACC_SEL_B, 8'h00);
  endtask : t_reset

  task automatic t_single();
    wr(ACC_SEL_A, 8'h43);
    `CHK({conv_start, conv_low_power, channel_select}, 7'h43)
    rd(ACC_SEL_B, 8'h80);
    wait_done();
    `CHK({conv_irq, conv_low_power, input_isolate}, 3'h6)
    starts(10);
    `CHK(c, 0)
    rd(ACC_SEL_A, 8'hc3);
    wr(ACC_SEL_A, 8'h9f);
    `CHK({input_isolate, conv_start}, 2'h2)
    rd(ACC_SEL_A, 8'h1f);
    `CHK(conv_irq, 1'h0)
  endtask : t_single

  // Writes land two cycles apart, well inside one conversion, so each
  // write after the first must abort a running conversion.
  task automatic t_chan();
    logic [4:0] codes [4] = '{5'h00, 5'h1b, 5'h1d, 5'h1e};
    for (int i = 0; i < 4; i++) begin
      wr(ACC_SEL_A, {3'h0, codes[i]});
      `CHK(channel_select, codes[i])
      if (i > 0) `CHK({conv_abort, conv_start}, 2'h3)
    end
    wait_done();
  endtask : t_chan

  task automatic t_cont();
    wr(ACC_SEL_A, 8'h22);
    starts(20);
    `CHK(c, 2)
    wr(ACC_SEL_A, 8'h3f);
    `CHK({conv_abort, conv_start}, 2'h2)
    starts(20);
    `CHK(c, 0)
    rd(ACC_SEL_A, 8'h3f);
  endtask : t_cont

  task automatic t_cmp();
    wr(ACC_SEL_B, 8'h20);
    ge_level = 1'h1;
    wr(ACC_SEL_A, 8'h01);
    wait_done();
    `CHK(result_load, 1'h0)
    rd(ACC_SEL_A, 8'h01);
    ge_level = 1'h0;
    wr(ACC_SEL_A, 8'h01);
    wait_done();
    `CHK(result_load, 1'h1)
    rd(ACC_SEL_A, 8'h81);
    wr(ACC_SEL_B, 8'h30);
    rd(ACC_SEL_B, 8'h30);
    ge_level = 1'h1;
    wr(ACC_SEL_A, 8'h01);
    wait_done();
    rd(ACC_SEL_A, 8'h81);
    tick();
    result_low_read = 1'h1;
    tick();
    result_low_read = 1'h0;
    rd(ACC_SEL_A, 8'h01);
  endtask : t_cmp

  // The stop write lands one edge before the aborted conversion would
  // report, so its late done pulse must be ignored.
  task automatic t_hw();
    wr(ACC_SEL_B, 8'h40);
    wr(ACC_SEL_A, 8'h05);
    starts(5);
    `CHK(c, 0)
    hardware_trigger_in = 1'h1;
    starts(8);
    `CHK(c, 1)
    starts(30);
    `CHK(c, 0)
    hardware_trigger_in = 1'h0;
    rd(ACC_SEL_B, 8'h40);
    rd(ACC_SEL_A, 8'h85);
    wr(ACC_SEL_A, 8'h25);
    starts(5);
    `CHK(c, 0)
    hardware_trigger_in = 1'h1;
    starts(17);
    `CHK(c, 2)
    wr(ACC_SEL_A, 8'h3f);
    `CHK({conv_abort, conv_start}, 2'h2)
    starts(20);
    `CHK(c, 0)
    hardware_trigger_in = 1'h0;
    rd(ACC_SEL_A, 8'h3f);
    rd(ACC_SEL_B, 8'h40);
  endtask : t_hw

  task automatic t_rerst();
    wr(ACC_SEL_A, 8'h47);
    tick();
    nrst = 1'h0;
    tick();
    nrst = 1'h1;
    `CHK({channel_select, conv_low_power, conv_irq}, 7'h7e)
    rd(ACC_SEL_A, 8'h1f);
    rd(ACC_SEL_B, 8'h00);
  endtask : t_rerst

  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'h1;
    t_reset();
    t_single();
    t_chan();
    t_cont();
    t_cmp();
    t_hw();
    t_rerst();
    close_out();
  end
endmodule : acc_ctrl_tb

// File: acc_pkg.sv
// Package of constants for the converter control and status block.
// Functional notes
// - Writing register A aborts any conversion and, with trigger select zero, starts anew unless channel is all ones.
// - Done flag at bit 7 is read-only; written bit values are ignored.
// - With compare off, every completed conversion sets the done flag.
// - With compare on, done flag sets only when compare is true.
// - Done flag clears on any register A write or low result byte read; a completion in the same cycle sets it instead.
// - Interrupt request asserts while done flag is set and enable bit 6 is one.
// - Continuous bit 5 clear gives one conversion per write or trigger.
// - Continuous bit 5 set repeats conversions back to back after the start.
// - Channel field bits 4:0; 0 to 27 inputs, 29 high, 30 low reference.
// - Channel code all ones turns converter off and isolates the input.
// - Stopping continuous mode with all ones runs no further conversion.
// - Without continuous mode converter drops to low power after each conversion.
// - Active bit 7 of register B tracks a conversion from start to end or abort.
// - Trigger select bit 6: zero starts on writes, one on hardware trigger.
// - Compare enable bit 5 switches the automatic compare on or off.
// - Compare direction bit 4: one means greater or equal, zero less than.
// - In hardware mode each wakeup counter overflow starts a conversion unless one is already running.
// - Result loads at each completion, unless compare is on and false.
package acc_pkg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  localparam logic       ACC_SEL_A     = 1'h0;
  localparam logic       ACC_SEL_B     = 1'h1;

  // ----------------------------------------------------------------
  // Register A fields
  // ----------------------------------------------------------------
  localparam int         ACC_A_DONE    = 7;
  localparam int         ACC_A_IEN     = 6;
  localparam int         ACC_A_CONT    = 5;
  localparam int         ACC_A_CH_MSB  = 4;
  localparam int         ACC_A_CH_LSB  = 0;

  // ----------------------------------------------------------------
  // Register B fields
  // ----------------------------------------------------------------
  localparam int         ACC_B_ACTIVE  = 7;
  localparam int         ACC_B_TRIG    = 6;
  localparam int         ACC_B_CMP_EN  = 5;
  localparam int         ACC_B_CMP_GE  = 4;
  localparam logic [3:0] ACC_B_LOW_RD  = 4'h0;

  // ----------------------------------------------------------------
  // Channel codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] ACC_CH_LAST_IN = 5'h1b;
  localparam logic [4:0] ACC_CH_RSVD    = 5'h1c;
  localparam logic [4:0] ACC_CH_REF_HI  = 5'h1d;
  localparam logic [4:0] ACC_CH_REF_LO  = 5'h1e;
  localparam logic [4:0] ACC_CH_OFF     = 5'h1f;
  localparam logic [4:0] ACC_CH_RST     = ACC_CH_OFF;
  localparam logic       ACC_BIT_RST    = 1'h0;
  localparam logic [7:0] ACC_RDATA_RST  = 8'h00;

endpackage : acc_pkg

// File: acc_trig_edge.sv
// Synchroniser and rising edge detector for the hardware trigger.
`timescale 1ns/100ps
module acc_trig_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Trigger level and start pulse
  input  wire logic trig_in,
  output logic      trig_pulse
);

  logic sync1_r;
  logic sync2_r;
  logic last_r;

  // ----------------------------------------------------------------
  // Two stages, then a third flop to find the rising edge.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r    <= 1'h0;
      sync2_r    <= 1'h0;
      last_r     <= 1'h0;
      trig_pulse <= 1'h0;
    end else begin
      sync1_r    <= trig_in;
      sync2_r    <= sync1_r;
      last_r     <= sync2_r;
      trig_pulse <= sync2_r && !last_r;
    end
  end

endmodule : acc_trig_edge
